// >>> rtl/angs_pkg.sv
// Constants for the autonegotiation and gigabit status register bank.
// Assumes a word-wide AHB-Lite bus; register byte address is four times its index.
package angs_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ANGS_IDX_BASE_ABIL = 12'h005;
  localparam logic [11:0] ANGS_IDX_EXPANSION = 12'h006;
  localparam logic [11:0] ANGS_IDX_NP_TX = 12'h007;
  localparam logic [11:0] ANGS_IDX_NP_RX = 12'h008;
  localparam logic [11:0] ANGS_IDX_GIG_CTRL = 12'h009;
  localparam logic [11:0] ANGS_IDX_GIG_STAT = 12'h00A;
  localparam logic [11:0] ANGS_IDX_INT_STAT = 12'h010;
  localparam logic [11:0] ANGS_IDX_INT_MASK = 12'h011;
  localparam logic [11:0] ANGS_ADDR_STEP = 12'h004;
  // ----------------------------------------------------------------
  // Reset values and write mask
  // ----------------------------------------------------------------
  localparam logic [15:0] ANGS_NP_TX_RST = 16'h2001;
  localparam logic [15:0] ANGS_GIG_CTRL_RST = 16'h0700;
  localparam logic [15:0] ANGS_NP_TX_WMASK = 16'hB7FF;
  // ----------------------------------------------------------------
  // Field positions, interrupt width and idle counter limits
  // ----------------------------------------------------------------
  localparam int ANGS_EXP_PD_FAULT = 4;
  localparam int ANGS_EXP_LP_NP = 3;
  localparam int ANGS_EXP_LOC_NP = 2;
  localparam int ANGS_EXP_PAGE_RX = 1;
  localparam int ANGS_EXP_LP_AN = 0;
  localparam int ANGS_NPT_TOGGLE = 11;
  localparam int ANGS_GC_MAN_MS = 12;
  localparam int ANGS_GC_MS_VAL = 11;
  localparam int ANGS_GS_MS_FAULT = 15;
  localparam int ANGS_GS_ROLE = 14;
  localparam int ANGS_GS_LOC_RX = 13;
  localparam int ANGS_GS_REM_RX = 12;
  localparam int ANGS_GS_LP_FDX = 11;
  localparam int ANGS_GS_LP_HDX = 10;
  localparam int ANGS_INT_W = 5;
  localparam logic [7:0] ANGS_IDLE_MAX = 8'hFF;
  localparam logic [7:0] ANGS_IDLE_ONE = 8'h01;
  // ----------------------------------------------------------------
  // Transmitter test modes and AHB-Lite transfer codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ANGS_TM_NORMAL = 3'h0;
  localparam logic [2:0] ANGS_TM_LAST = 3'h4;
  localparam logic [1:0] ANGS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ANGS_HSIZE_WORD = 3'h2;
endpackage

// >>> rtl/angs_regs.sv
// Autonegotiation and gigabit control/status register bank behind an AHB-Lite slave.
// Assumes the PHY core drives all status inputs on CLOCK; zero-wait-state bus answers.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// RULE_01: Register 5 shows the partner base page read-only, all fields zero after reset.
// RULE_02: Expansion bit 4 latches high on a parallel detection fault until read.
// RULE_03: Expansion bit 1 shows page reception, latches low, and is zero after reset.
// RULE_04: Expansion bit 2 reads 1, bit 3 and bit 0 show partner abilities, bits 15:5 read zero.
// RULE_05: Register 7 holds writable next page fields with message page and code one after reset.
// RULE_06: Transmit toggle bit 11 is the inverse of the toggle in the last sent link codeword.
// RULE_07: Register 8 shows the partner next page read-only, all fields zero after reset.
// RULE_08: Gigabit control bits 15:13 select the transmitter test mode, reserved codes above 100.
// RULE_09: Software turns off automatic media sensing before picking a nonzero test mode.
// RULE_10: Bit 11 forces the role only while manual configuration bit 12 is set.
// RULE_11: Port type and duplex bits reset to one and reserved bits 7:0 reset to zero.
// RULE_12: Status bit 15 latches high on a master/slave fault until read.
// RULE_13: Status bit 14 shows the resolved role and reads master after reset.
// RULE_14: Status bits 13 and 12 show local and remote receiver health, zero after reset.
// RULE_15: Status bits 11 and 10 show partner gigabit duplex abilities and bits 9:8 read zero.
// RULE_16: Status bits 7:0 count idle errors, reset to zero and clear on read.
// RULE_17: Latched bits refresh on the read that returns them and the idle counter saturates.
module angs_regs
  import angs_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic BASE_PAGE_VALID,
  input wire logic [15:0] BASE_PAGE,
  input wire logic NEXT_PAGE_VALID,
  input wire logic [15:0] NEXT_PAGE,
  input wire logic LINK_CODEWORD_SENT,
  input wire logic LINK_CODEWORD_TOGGLE,
  input wire logic PARALLEL_FAULT,
  input wire logic PAGE_RECEIVED,
  input wire logic LINK_PARTNER_NP_ABLE,
  input wire logic LINK_PARTNER_AN_ABLE,
  input wire logic MS_FAULT,
  input wire logic MS_RESOLVED_MASTER,
  input wire logic LOCAL_RX_OK,
  input wire logic REMOTE_RX_OK,
  input wire logic LINK_PARTNER_GIG_FDX,
  input wire logic LINK_PARTNER_GIG_HDX,
  input wire logic IDLE_ERROR,
  output logic [15:0] NP_TX_WORD,
  output logic [2:0] TX_TEST_MODE,
  output logic MS_FORCE_EN,
  output logic MS_FORCE_MASTER,
  output logic PORT_MULTI,
  output logic GIG_FDX_ABLE,
  output logic GIG_HDX_ABLE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] base_abil;
    logic [15:0] np_rx;
    logic [15:0] np_tx;
    logic toggle;
    logic [15:0] gig_ctrl;
    logic pd_fault;
    logic page_lat;
    logic page_prev;
    logic ms_fault;
    logic [7:0] idle_cnt;
    logic [ANGS_INT_W-1:0] int_stat;
    logic [ANGS_INT_W-1:0] int_mask;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic [2:0] test_mode;
    logic force_master;
    logic irq;
  } angs_state_t;

  angs_state_t s_r;
  angs_state_t s_nxt;

  // Byte address match for one register index
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr == 12'(idx * ANGS_ADDR_STEP));
  endfunction

  logic take;
  logic [11:0] a_addr;
  logic [ANGS_INT_W-1:0] ev;
  logic [15:0] expansion;
  logic [15:0] gig_stat;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    take = HSEL && HREADY && (HTRANS == ANGS_HTRANS_NONSEQ);
    a_addr = HADDR[11:0];
    ev = {IDLE_ERROR, MS_FAULT, NEXT_PAGE_VALID, PAGE_RECEIVED && !s_r.page_prev, PARALLEL_FAULT};
    // Write data phase, applied before any read in the same cycle
    if (s_r.wr_pend)
    begin
      if (hit(s_r.wr_addr, ANGS_IDX_NP_TX))
      begin
        s_nxt.np_tx = HWDATA[15:0] & ANGS_NP_TX_WMASK; // see RULE_05
      end
      else if (hit(s_r.wr_addr, ANGS_IDX_GIG_CTRL))
      begin
        s_nxt.gig_ctrl = HWDATA[15:0]; // see RULE_11
      end
      else if (hit(s_r.wr_addr, ANGS_IDX_INT_STAT))
      begin
        s_nxt.int_stat = s_r.int_stat & ~HWDATA[ANGS_INT_W-1:0];
      end
      else if (hit(s_r.wr_addr, ANGS_IDX_INT_MASK))
      begin
        s_nxt.int_mask = HWDATA[ANGS_INT_W-1:0];
      end
    end
    // Captured partner pages
    if (BASE_PAGE_VALID)
    begin
      s_nxt.base_abil = BASE_PAGE; // see RULE_01
    end
    if (NEXT_PAGE_VALID)
    begin
      s_nxt.np_rx = NEXT_PAGE; // see RULE_07
    end
    if (LINK_CODEWORD_SENT)
    begin
      s_nxt.toggle = !LINK_CODEWORD_TOGGLE; // see RULE_06
    end
    // Read view of the composite registers
    expansion = '0; // see RULE_04
    expansion[ANGS_EXP_PD_FAULT] = s_r.pd_fault;
    expansion[ANGS_EXP_LP_NP] = LINK_PARTNER_NP_ABLE;
    expansion[ANGS_EXP_LOC_NP] = 1'b1;
    expansion[ANGS_EXP_PAGE_RX] = s_r.page_lat;
    expansion[ANGS_EXP_LP_AN] = LINK_PARTNER_AN_ABLE;
    gig_stat = {8'h00, s_r.idle_cnt}; // see RULE_15
    gig_stat[ANGS_GS_MS_FAULT] = s_r.ms_fault;
    gig_stat[ANGS_GS_ROLE] = MS_RESOLVED_MASTER; // see RULE_13
    gig_stat[ANGS_GS_LOC_RX] = LOCAL_RX_OK; // see RULE_14
    gig_stat[ANGS_GS_REM_RX] = REMOTE_RX_OK;
    gig_stat[ANGS_GS_LP_FDX] = LINK_PARTNER_GIG_FDX;
    gig_stat[ANGS_GS_LP_HDX] = LINK_PARTNER_GIG_HDX;
    // Latching bits: faults set, a low PAGE_RECEIVED clears, reads refresh, the event wins
    s_nxt.page_prev = PAGE_RECEIVED;
    s_nxt.page_lat = s_r.page_lat && PAGE_RECEIVED; // see RULE_03
    s_nxt.pd_fault = s_r.pd_fault || PARALLEL_FAULT; // see RULE_02
    s_nxt.ms_fault = s_r.ms_fault || MS_FAULT; // see RULE_12
    // Address phase: register read data, apply read side effects
    s_nxt.wr_pend = take && HWRITE;
    s_nxt.wr_addr = a_addr;
    if (take && !HWRITE)
    begin
      s_nxt.rdata = '0;
      if (hit(a_addr, ANGS_IDX_BASE_ABIL))
      begin
        s_nxt.rdata[15:0] = s_r.base_abil;
      end
      else if (hit(a_addr, ANGS_IDX_EXPANSION))
      begin
        s_nxt.rdata[15:0] = expansion;
        s_nxt.pd_fault = PARALLEL_FAULT; // see RULE_17
        s_nxt.page_lat = PAGE_RECEIVED; // see RULE_17
      end
      else if (hit(a_addr, ANGS_IDX_NP_TX))
      begin
        s_nxt.rdata[15:0] = s_nxt.np_tx | (16'(s_r.toggle) << ANGS_NPT_TOGGLE);
      end
      else if (hit(a_addr, ANGS_IDX_NP_RX))
      begin
        s_nxt.rdata[15:0] = s_r.np_rx;
      end
      else if (hit(a_addr, ANGS_IDX_GIG_CTRL))
      begin
        s_nxt.rdata[15:0] = s_nxt.gig_ctrl;
      end
      else if (hit(a_addr, ANGS_IDX_GIG_STAT))
      begin
        s_nxt.rdata[15:0] = gig_stat;
        s_nxt.ms_fault = MS_FAULT; // see RULE_17
        s_nxt.idle_cnt = '0; // see RULE_16
      end
      else if (hit(a_addr, ANGS_IDX_INT_STAT))
      begin
        s_nxt.rdata[ANGS_INT_W-1:0] = s_nxt.int_stat;
      end
      else if (hit(a_addr, ANGS_IDX_INT_MASK))
      begin
        s_nxt.rdata[ANGS_INT_W-1:0] = s_nxt.int_mask;
      end
    end
    // Idle error count saturates; an error in the read cycle counts anew
    if (IDLE_ERROR && (s_nxt.idle_cnt != ANGS_IDLE_MAX))
    begin
      s_nxt.idle_cnt = s_nxt.idle_cnt + ANGS_IDLE_ONE; // see RULE_17
    end
    // Sticky interrupt bits, set wins over clear
    s_nxt.int_stat = s_nxt.int_stat | ev;
    s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
    // Decoded controls; reserved test codes run as normal
    s_nxt.test_mode = (s_nxt.gig_ctrl[15:13] > ANGS_TM_LAST) ? ANGS_TM_NORMAL : s_nxt.gig_ctrl[15:13]; // see RULE_08
    s_nxt.force_master = s_nxt.gig_ctrl[ANGS_GC_MAN_MS] && s_nxt.gig_ctrl[ANGS_GC_MS_VAL]; // see RULE_10
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      s_r <= '0;
      s_r.np_tx <= ANGS_NP_TX_RST; // see RULE_05
      s_r.gig_ctrl <= ANGS_GIG_CTRL_RST; // see RULE_11
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs from flops; NP_TX_WORD merges the toggle flop, bus handshake is tied off
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s_r.rdata;
  assign NP_TX_WORD = s_r.np_tx | (16'(s_r.toggle) << ANGS_NPT_TOGGLE);
  assign TX_TEST_MODE = s_r.test_mode;
  assign MS_FORCE_EN = s_r.gig_ctrl[ANGS_GC_MAN_MS];
  assign MS_FORCE_MASTER = s_r.force_master;
  assign PORT_MULTI = s_r.gig_ctrl[10];
  assign GIG_FDX_ABLE = s_r.gig_ctrl[9];
  assign GIG_HDX_ABLE = s_r.gig_ctrl[8];
  assign IRQ = s_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic rd_stat;
  logic rd_exp;
  assign rd_stat = take && !HWRITE && hit(a_addr, ANGS_IDX_GIG_STAT);
  assign rd_exp = take && !HWRITE && hit(a_addr, ANGS_IDX_EXPANSION);
  logic rd_base;
  logic rd_nprx;
  logic wr_npt;
  logic wr_gc;
  assign rd_base = take && !HWRITE && hit(a_addr, ANGS_IDX_BASE_ABIL);
  assign rd_nprx = take && !HWRITE && hit(a_addr, ANGS_IDX_NP_RX);
  // Data phase of a write to the next page or control register
  assign wr_npt = s_r.wr_pend && hit(s_r.wr_addr, ANGS_IDX_NP_TX);
  assign wr_gc = s_r.wr_pend && hit(s_r.wr_addr, ANGS_IDX_GIG_CTRL);

  sequence fault_seen;
    MS_FAULT ##1 1'b1;
  endsequence

  chk_base_capture: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_01
    BASE_PAGE_VALID |=> (s_r.base_abil == $past(BASE_PAGE)))
    else $error("base page not captured");
  chk_pd_latch: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_02
    (PARALLEL_FAULT ##1 !rd_exp) |=> s_r.pd_fault)
    else $error("parallel fault not latched");
  chk_page_low: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_03
    (!PAGE_RECEIVED && !rd_exp) |=> !s_r.page_lat)
    else $error("page received did not latch low");
  chk_exp_fixed: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_04
    rd_exp |=> (HRDATA[31:5] == '0) && HRDATA[ANGS_EXP_LOC_NP])
    else $error("expansion fixed bits wrong");
  chk_toggle_inv: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_06
    LINK_CODEWORD_SENT |=> (NP_TX_WORD[ANGS_NPT_TOGGLE] != $past(LINK_CODEWORD_TOGGLE)))
    else $error("toggle not inverted");
  chk_np_capture: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_07
    NEXT_PAGE_VALID |=> (s_r.np_rx == $past(NEXT_PAGE)) && s_r.int_stat[2] && (IRQ || !s_r.int_mask[2]))
    else $error("next page not captured");
  chk_test_mode: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_08
    TX_TEST_MODE <= ANGS_TM_LAST)
    else $error("reserved test mode driven");
  chk_force_role: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_10
    !MS_FORCE_EN |-> !MS_FORCE_MASTER)
    else $error("role forced without manual mode");
  chk_ms_latch: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_12
    (fault_seen ##0 !rd_stat) |=> s_r.ms_fault)
    else $error("master/slave fault not latched");
  chk_idle_clear: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_16
    (rd_stat && !IDLE_ERROR) |=> (s_r.idle_cnt == '0) && (HRDATA[7:0] == $past(s_r.idle_cnt)))
    else $error("idle count not cleared on read");
  chk_idle_sat: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_17
    (s_r.idle_cnt == ANGS_IDLE_MAX && !rd_stat) |=> (s_r.idle_cnt == ANGS_IDLE_MAX))
    else $error("idle count wrapped");
  chk_base_read: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_01
    rd_base |=> (HRDATA == {16'h0000, $past(s_r.base_abil)}))
    else $error("base page read wrong");
  chk_npt_write: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_05
    wr_npt |=> ((NP_TX_WORD & ANGS_NP_TX_WMASK) == (16'($past(HWDATA)) & ANGS_NP_TX_WMASK)))
    else $error("next page write not stored");
  chk_npt_fixed: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_05
    (NP_TX_WORD & ~(ANGS_NP_TX_WMASK | (16'h0001 << ANGS_NPT_TOGGLE))) == 16'h0000)
    else $error("reserved next page bit set");
  chk_nprx_read: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_07
    rd_nprx |=> (HRDATA == {16'h0000, $past(s_r.np_rx)}))
    else $error("partner next page read wrong");
  chk_mode_pass: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_08
    (s_r.gig_ctrl[15:13] <= ANGS_TM_LAST) |-> (TX_TEST_MODE == s_r.gig_ctrl[15:13]))
    else $error("test mode not passed on");
  chk_force_on: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_10
    MS_FORCE_EN |-> (MS_FORCE_MASTER == s_r.gig_ctrl[ANGS_GC_MS_VAL]))
    else $error("forced role does not follow value bit");
  chk_gc_write: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_11
    wr_gc |=> (s_r.gig_ctrl == 16'($past(HWDATA))))
    else $error("control write not stored");
  chk_role_live: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_13
    rd_stat |=> (HRDATA[ANGS_GS_ROLE] == $past(MS_RESOLVED_MASTER)))
    else $error("resolved role read wrong");
  chk_rx_live: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_14
    rd_stat |=> (HRDATA[ANGS_GS_LOC_RX] == $past(LOCAL_RX_OK)) && (HRDATA[ANGS_GS_REM_RX] == $past(REMOTE_RX_OK)))
    else $error("receiver status read wrong");
  chk_lp_gig: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_15
    rd_stat |=> (HRDATA[ANGS_GS_LP_FDX] == $past(LINK_PARTNER_GIG_FDX))
      && (HRDATA[ANGS_GS_LP_HDX] == $past(LINK_PARTNER_GIG_HDX))
      && (HRDATA[ANGS_GS_LP_HDX-1 -: 2] == 2'b00) && (HRDATA[31:16] == 16'h0000))
    else $error("partner gigabit abilities read wrong");
  chk_pd_clear: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_17
    (rd_exp && !PARALLEL_FAULT) |=> !s_r.pd_fault)
    else $error("parallel fault not cleared by read");
  chk_ms_clear: assert property (@(posedge CLOCK) disable iff (SRST) // see RULE_17
    (rd_stat && !MS_FAULT) |=> !s_r.ms_fault)
    else $error("master/slave fault not cleared by read");
  chk_int_sticky: assert property (@(posedge CLOCK) disable iff (SRST)
    !s_r.wr_pend |=> ((s_r.int_stat & $past(s_r.int_stat)) == $past(s_r.int_stat)))
    else $error("interrupt status bit lost without a write");

endmodule // angs_regs

// >>> testbench/angs_core_model.sv
// Behavioural stand-in for the PHY core and the link partner that feed the bank.
// Assumes callers invoke its tasks just after a rising CLOCK edge.
`timescale 1ns/1ps
module angs_core_model
(
  input wire logic CLOCK,
  output logic [5:0] PLS,
  output logic [8:0] LVL,
  output logic [15:0] BASE_PAGE,
  output logic [15:0] NEXT_PAGE
);
  logic [15:0] base_r;
  logic [15:0] np_r;
  // Unqualified page buses show the inverse so stale data never passes
  assign BASE_PAGE = PLS[0] ? base_r : ~base_r;
  assign NEXT_PAGE = PLS[1] ? np_r : ~np_r;
  // Quiet start, core resolved to master
  initial
  begin
    PLS = 6'h00;
    LVL = 9'h010;
    base_r = 16'h0000;
    np_r = 16'h0000;
  end
  // One-cycle event strobe, then one idle cycle
  task automatic pulse(input int i);
    PLS[i] <= 1'b1;
    @(posedge CLOCK);
    PLS[i] <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Live status levels
  task automatic level(input logic [8:0] v);
    LVL <= v;
  endtask
  // Received base and next pages
  task automatic pages(input logic [15:0] b, input logic [15:0] n);
    base_r <= b;
    np_r <= n;
  endtask
endmodule // angs_core_model

// >>> testbench/test_angs_regs.sv
// Self-checking bench for the register bank, driven as an AHB-Lite master.
// Assumes the core model sits on the status inputs and zero-wait answers.
`timescale 1ns/1ps
module test_angs_regs import angs_pkg::*;;
  logic CLOCK, SRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, r, e;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, TX_TEST_MODE;
  logic [5:0] PLS;
  logic [8:0] LVL, v;
  logic [15:0] BASE_PAGE, NEXT_PAGE, NP_TX_WORD;
  logic MS_FORCE_EN, MS_FORCE_MASTER, PORT_MULTI, GIG_FDX_ABLE, GIG_HDX_ABLE;
  int num_errors, cmp_count, k, n;
  int pm [5] = '{3, 1, 1, 4, 5};
  logic [11:0] tidx [8] = '{ANGS_IDX_BASE_ABIL, ANGS_IDX_EXPANSION, ANGS_IDX_NP_TX, ANGS_IDX_NP_RX,
    ANGS_IDX_GIG_CTRL, ANGS_IDX_GIG_STAT, ANGS_IDX_INT_STAT, 12'h003};
  logic [31:0] texp [8] = '{32'h0, 32'h4, 32'h2001, 32'h0, 32'h700, 32'h4000, 32'h0, 32'h0};
  assign HREADY = HREADYOUT;
  angs_core_model core (.CLOCK(CLOCK), .PLS(PLS), .LVL(LVL), .BASE_PAGE(BASE_PAGE), .NEXT_PAGE(NEXT_PAGE));
  angs_regs uut (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .BASE_PAGE_VALID(PLS[0]), .BASE_PAGE(BASE_PAGE), .NEXT_PAGE_VALID(PLS[1]), .NEXT_PAGE(NEXT_PAGE),
    .LINK_CODEWORD_SENT(PLS[2]), .LINK_CODEWORD_TOGGLE(LVL[0]), .PARALLEL_FAULT(PLS[3]), .PAGE_RECEIVED(LVL[1]),
    .LINK_PARTNER_NP_ABLE(LVL[2]), .LINK_PARTNER_AN_ABLE(LVL[3]), .MS_FAULT(PLS[4]), .MS_RESOLVED_MASTER(LVL[4]),
    .LOCAL_RX_OK(LVL[5]), .REMOTE_RX_OK(LVL[6]), .LINK_PARTNER_GIG_FDX(LVL[7]), .LINK_PARTNER_GIG_HDX(LVL[8]),
    .IDLE_ERROR(PLS[5]), .NP_TX_WORD(NP_TX_WORD), .TX_TEST_MODE(TX_TEST_MODE), .MS_FORCE_EN(MS_FORCE_EN),
    .MS_FORCE_MASTER(MS_FORCE_MASTER), .PORT_MULTI(PORT_MULTI), .GIG_FDX_ABLE(GIG_FDX_ABLE),
    .GIG_HDX_ABLE(GIG_HDX_ABLE), .IRQ(IRQ));
  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp6(input logic [8:0] s, input logic pf, input logic pr);
    exp6 = {27'h0, pf, s[2], 1'b1, pr, s[3]};
  endfunction
  function automatic logic [31:0] exp10(input logic [8:0] s, input logic mf, input logic [7:0] c);
    exp10 = {16'h0, mf, s[4], s[5], s[6], s[7], s[8], 2'b00, c};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the slave's ready
  task automatic ready_wait;
    int c;
    c = 0;
    do
    begin
      @(posedge CLOCK);
      c++;
    end
    while (HREADYOUT !== 1'b1 && c < 50);
    if (c >= 50)
    begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HSIZE <= ANGS_HSIZE_WORD;
    HTRANS <= ANGS_HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {20'h0, idx * ANGS_ADDR_STEP};
    ready_wait();
    HSEL <= 1'b0;
    HSIZE <= 3'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    ready_wait();
    q = HRDATA;
    chk({31'h0, HRESP}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] x);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, q);
    chk(q, x);
  endtask
  // Interrupt level is given two cycles to settle
  task automatic irq_is(input logic x);
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, {31'h0, x});
  endtask
  task automatic irq_case(input int b, input int p);
    wr(ANGS_IDX_INT_MASK, 32'h0);
    wr(ANGS_IDX_INT_STAT, 32'h1F);
    if (b == 1)
    begin
      core.level(LVL & ~9'h002);
      @(posedge CLOCK);
      core.level(LVL | 9'h002);
      @(posedge CLOCK);
    end
    else
      core.pulse(p);
    irq_is(1'b0);
    rd(ANGS_IDX_INT_STAT, 32'h1 << b);
    wr(ANGS_IDX_INT_MASK, 32'h1 << b);
    irq_is(1'b1);
    wr(ANGS_IDX_INT_STAT, 32'h1 << b);
    irq_is(1'b0);
  endtask
  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  initial
  begin
    {SRST, HSEL, HWRITE, HADDR, HWDATA, HTRANS, num_errors, cmp_count} = {3'b100, 66'h0, 64'h0};
    HSIZE = ANGS_HSIZE_WORD;
    void'($urandom(15));
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    for (k = 0; k < 8; k++)
      rd(tidx[k], texp[k]);
    chk({NP_TX_WORD, TX_TEST_MODE, MS_FORCE_EN, MS_FORCE_MASTER, PORT_MULTI, GIG_FDX_ABLE, GIG_HDX_ABLE},
      {16'h2001, 8'h07});
    $display("test reset finished");
    r = $urandom();
    core.pages(r[15:0], r[31:16]);
    core.pulse(0);
    core.pulse(1);
    for (k = 0; k < 2; k++)
    begin
      rd(ANGS_IDX_BASE_ABIL, {16'h0, r[15:0]});
      rd(ANGS_IDX_NP_RX, {16'h0, r[31:16]});
      wr(ANGS_IDX_BASE_ABIL, ~r);
      wr(ANGS_IDX_NP_RX, r);
    end
    r = $urandom();
    wr(ANGS_IDX_NP_TX, r);
    for (k = 1; k >= 0; k--)
    begin
      e = {16'h0, r[15:0] & ANGS_NP_TX_WMASK | {4'h0, ~k[0], 11'h0}};
      core.level({LVL[8:1], k[0]});
      core.pulse(2);
      rd(ANGS_IDX_NP_TX, e);
      chk({16'h0, NP_TX_WORD}, e);
    end
    for (k = 0; k < 8; k++)
    begin
      r = $urandom();
      r = {16'h0, k[2:0], r[12:0]};
      wr(ANGS_IDX_GIG_CTRL, r); // media sensing counts as off here
      rd(ANGS_IDX_GIG_CTRL, r);
      chk({TX_TEST_MODE, MS_FORCE_EN, MS_FORCE_MASTER, PORT_MULTI, GIG_FDX_ABLE, GIG_HDX_ABLE},
        {(k <= ANGS_TM_LAST) ? k[2:0] : ANGS_TM_NORMAL, r[12], r[12] & r[11], r[10:8]});
    end
    // A request with the slave unselected must leave the control word alone
    HTRANS <= ANGS_HTRANS_NONSEQ;
    HWRITE <= 1'b1;
    HADDR <= {20'h0, ANGS_IDX_GIG_CTRL * ANGS_ADDR_STEP};
    ready_wait();
    HTRANS <= 2'h0;
    HWDATA <= ~r;
    ready_wait();
    rd(ANGS_IDX_GIG_CTRL, r);
    $display("test pages and control finished");
    r = $urandom();
    v = {r[8:2], 1'b0, r[0]};
    core.level(v);
    core.pulse(3);
    core.pulse(4);
    for (k = 1; k >= 0; k--)
    begin
      rd(ANGS_IDX_EXPANSION, exp6(v, k[0], 1'b0));
      rd(ANGS_IDX_GIG_STAT, exp10(v, k[0], 8'h00));
    end
    v[1] = 1'b1;
    for (k = 0; k < 2; k++)
    begin
      if (k == 1)
      begin
        core.level(v ^ 9'h002);
        @(posedge CLOCK);
      end
      core.level(v);
      @(posedge CLOCK);
      rd(ANGS_IDX_EXPANSION, exp6(v, 1'b0, 1'b0));
      rd(ANGS_IDX_EXPANSION, exp6(v, 1'b0, 1'b1));
    end
    n = $urandom_range(20, 1);
    repeat (n) core.pulse(5);
    rd(ANGS_IDX_GIG_STAT, exp10(v, 1'b0, n[7:0]));
    rd(ANGS_IDX_GIG_STAT, exp10(v, 1'b0, 8'h00));
    repeat (260) core.pulse(5);
    rd(ANGS_IDX_GIG_STAT, exp10(v, 1'b0, ANGS_IDLE_MAX));
    $display("test latches and counter finished");
    for (k = 0; k < 5; k++)
      irq_case(k, pm[k]);
    $display("test interrupts finished");
    complete_run();
  end
endmodule // test_angs_regs
